// ==== hdl/vpm_pkg.sv ====
// package for the voltage, cos phi and active power limit monitors
// assumes a single 20 MHz system clock and a classic wishbone host
package vpm_pkg;
  // monitor slots: 0 volt trip, 1 volt warn, 2 pf trip, 3 pf warn,
  // 4 p> trip, 5 p> warn, 6 p< trip, 7 p< warn
  localparam int         VPM_NMON       = 8;
  localparam logic [7:0] VPM_TRIP_KIND  = 8'h55;
  localparam logic [7:0] VPM_UPPER_KIND = 8'h30;
  localparam logic [7:0] VPM_VOLT_KIND  = 8'h03;

  // register byte offsets
  localparam logic [7:0] VPM_CTRL_OFS  = 8'h00;
  localparam logic [7:0] VPM_VLVL_OFS  = 8'h04;
  localparam logic [7:0] VPM_PFLVL_OFS = 8'h08;
  localparam logic [7:0] VPM_PWR_OFS   = 8'h10;
  localparam logic [7:0] VPM_RESP_OFS  = 8'h20;
  localparam logic [7:0] VPM_STAT_OFS  = 8'h40;

  // field positions
  localparam int VPM_CTRL_VACT_POS = 8;
  localparam int VPM_LVL_WARN_POS  = 8;
  localparam int VPM_RESP_DLY_POS  = 8;

  // values after reset
  localparam logic [3:0] VPM_HYST_RST = 4'h5;
  localparam logic [7:0] VPM_DLY_RST  = 8'h05;
  localparam logic [7:0] VPM_VLVL_RST = 8'h00;
  localparam logic [6:0] VPM_PF_RST   = 7'h00;
  localparam logic [31:0] VPM_PWR_RST = 32'h0000_0000;

  // scaling: 8 V per voltage code, percent full scale
  localparam int          VPM_VSTEP_SHIFT = 3;
  localparam logic [35:0] VPM_PCT_FULL    = 36'h064;
  localparam logic [6:0]  VPM_PF_MAX      = 7'h64;

  // delay step of 0.1 s expressed in clock cycles
  localparam int VPM_CLK_HZ       = 20_000_000;
  localparam int VPM_DLY_STEP_MS  = 100;
  localparam int VPM_DLY_STEP_CYC = VPM_CLK_HZ / 1000 * VPM_DLY_STEP_MS;

  typedef enum logic [1:0] {
    VPM_RSP_OFF    = 2'h0,
    VPM_RSP_SIGNAL = 2'h1,
    VPM_RSP_WARN   = 2'h2,
    VPM_RSP_TRIP   = 2'h3
  } vpm_resp_t;

  typedef enum logic [1:0] {
    VPM_ACT_ON     = 2'h0,
    VPM_ACT_ON_TPF = 2'h1,
    VPM_ACT_RUN    = 2'h2
  } vpm_act_t;
endpackage : vpm_pkg

// ==== hdl/vpm_mon_if.sv ====
// interface between the top and one limit monitor slot
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface vpm_mon_if;
  logic [31:0] thr;
  logic [31:0] val;
  logic        upper;
  logic        active;
  logic [3:0]  hyst;
  logic [7:0]  dly;
  logic        tick;
  logic        cond;
  logic        fired;
  modport mon (input thr, val, upper, active, hyst, dly, tick,
               output cond, fired);
  modport ctl (output thr, val, upper, active, hyst, dly, tick,
               input cond, fired);
endinterface : vpm_mon_if

// ==== hdl/vpm_limit_mon.sv ====
// one limit slot: hysteresis comparator and response delay timer
// assumes tick pulses once per delay step on the same clock
`timescale 1ns/1ps
module vpm_limit_mon (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // slot carrier
  vpm_mon_if.mon   m
);
  import vpm_pkg::*;

  logic [35:0] prod;
  logic [31:0] band;
  logic [32:0] rel_hi;
  logic [31:0] rel_lo;
  logic        cond_r, cond_nxt;
  logic        fired_r, fired_nxt;
  logic [7:0]  cnt_r, cnt_nxt;

  // hysteresis band as a fraction of the threshold
  always_comb begin
    prod   = 36'(m.thr) * 36'(m.hyst);
    band   = 32'(prod / VPM_PCT_FULL);
    rel_hi = {1'b0, m.thr} + {1'b0, band};
    rel_lo = m.thr - band;
  end

  // set on crossing, release only past the band
  always_comb begin
    cond_nxt = cond_r;
    if (!m.active) begin
      cond_nxt = 1'b0;
    end else if (!cond_r) begin
      cond_nxt = m.upper ? (m.val > m.thr) : (m.val < m.thr);
    end else if (m.upper) begin
      cond_nxt = !(m.val < rel_lo);
    end else begin
      cond_nxt = !({1'b0, m.val} > rel_hi);
    end
  end

  // delay timer restarts whenever the condition drops
  always_comb begin
    cnt_nxt   = cnt_r;
    fired_nxt = fired_r;
    if (!cond_r) begin
      cnt_nxt   = 8'h00;
      fired_nxt = 1'b0;
    end else if (cnt_r >= m.dly) begin
      fired_nxt = 1'b1;
    end else if (m.tick) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cond_r  <= 1'b0;
      fired_r <= 1'b0;
      cnt_r   <= 8'h00;
    end else begin
      cond_r  <= cond_nxt;
      fired_r <= fired_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign m.cond  = cond_r;
  assign m.fired = fired_r;
endmodule : vpm_limit_mon

// ==== hdl/vpm_monitor_top.sv ====
// voltage, cos phi and active power limit monitors with wishbone regs
// assumes measured values arrive from logic on the same clock
//
// What this block does
// - undervoltage judged on the smallest measured voltage, three or one phase
// - voltage trip and warn levels 0 to 2040 V in 8 V steps, reset zero
// - voltage responds when minimum voltage drops below trip or warn level
// - voltage keeps being evaluated while the motor is off
// - voltage activity always or always-except-test-position, the latter after reset
// - third voltage activity: only with motor on and no test position
// - voltage trip response off, signal or trip; delay 0-25.5 s, 0.5 s
// - voltage warn response off, signal or warn; delay 0-25.5 s, 0.5 s
// - one hysteresis 0-15 percent in 1 percent steps, 5 after reset
// - cos phi levels 0 to 100 percent, reset zero, 100 means 1.00
// - cos phi responds when measured power factor drops below a level
// - cos phi and power only judged when running, started, no test position
// - cos phi trip response off, signal or trip; delay 0-25.5 s, 0.5 s
// - cos phi warn response off, signal or warn; delay 0-25.5 s, 0.5 s
// - separate upper and lower power levels, 32-bit watts, reset zero
// - power responds above an upper level or below a lower level
// - power trip response off, signal or trip; delay 0-25.5 s, 0.5 s
`timescale 1ns/1ps
module vpm_monitor_top #(
  parameter int unsigned DLY_STEP_CYC = vpm_pkg::VPM_DLY_STEP_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  // measured values, volts, percent and watts
  input  wire logic [11:0] u_l1_i,
  input  wire logic [11:0] u_l2_i,
  input  wire logic [11:0] u_l3_i,
  input  wire logic        single_phase_i,
  input  wire logic [6:0]  pf_meas_i,
  input  wire logic [31:0] pwr_meas_i,
  // motor state
  input  wire logic        motor_on_i,
  input  wire logic        motor_started_i,
  input  wire logic        test_position_feedback_i,
  // responses
  output logic             signal_o,
  output logic             warn_o,
  output logic             trip_o
);
  import vpm_pkg::*;

  // configuration state
  logic [3:0]  hyst_r, hyst_nxt;
  vpm_act_t    vact_r, vact_nxt;
  logic [7:0]  vtrip_r, vtrip_nxt;
  logic [7:0]  vwarn_r, vwarn_nxt;
  logic [6:0]  pftrip_r, pftrip_nxt;
  logic [6:0]  pfwarn_r, pfwarn_nxt;
  logic [31:0] pwr_r [4];
  logic [31:0] pwr_nxt [4];
  vpm_resp_t   resp_r [VPM_NMON];
  vpm_resp_t   resp_nxt [VPM_NMON];
  logic [7:0]  dly_r [VPM_NMON];
  logic [7:0]  dly_nxt [VPM_NMON];

  // bus and output state
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic        sig_r, sig_nxt;
  logic        wrn_r, wrn_nxt;
  logic        trp_r, trp_nxt;
  logic [31:0] pre_r, pre_nxt;
  logic        tick_r, tick_nxt;

  // slot wiring
  logic [11:0] umin;
  logic        vact_on;
  logic        pact_on;
  logic [31:0] thr_w [VPM_NMON];
  logic [31:0] val_w [VPM_NMON];
  logic [7:0]  cond_w;
  logic [7:0]  fired_w;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic [7:0]  adr_w;
  logic        acc;
  logic        wr_en;

  // byte-lane merge for partial writes
  function automatic logic [31:0] vpm_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : vpm_merge

  // drop a response code that the slot does not offer
  function automatic vpm_resp_t vpm_legal(input logic [1:0] code,
                                          input logic       trip_kind);
    vpm_resp_t r;
    r = vpm_resp_t'(code);
    if (trip_kind && r == VPM_RSP_WARN) begin
      r = VPM_RSP_OFF;
    end
    if (!trip_kind && r == VPM_RSP_TRIP) begin
      r = VPM_RSP_OFF;
    end
    return r;
  endfunction : vpm_legal

  // smallest phase voltage; single phase uses the first input only
  always_comb begin
    umin = u_l1_i;
    if (!single_phase_i) begin
      if (u_l2_i < umin) begin
        umin = u_l2_i;
      end
      if (u_l3_i < umin) begin
        umin = u_l3_i;
      end
    end
  end

  // activity gates; voltage does not need the motor running by default
  always_comb begin
    unique case (vact_r)
      VPM_ACT_ON:     vact_on = 1'b1;
      VPM_ACT_ON_TPF: vact_on = !test_position_feedback_i;
      VPM_ACT_RUN:    vact_on = motor_on_i && !test_position_feedback_i;
      default:        vact_on = motor_on_i && !test_position_feedback_i;
    endcase
    pact_on = motor_on_i && motor_started_i && !test_position_feedback_i;
  end

  // per-slot thresholds and measured values, all widened to 32 bits
  always_comb begin
    for (int i = 0; i < VPM_NMON; i++) begin
      thr_w[i] = 32'h0000_0000;
      val_w[i] = pwr_meas_i;
    end
    thr_w[0] = 32'({vtrip_r, 3'h0});
    thr_w[1] = 32'({vwarn_r, 3'h0});
    val_w[0] = 32'(umin);
    val_w[1] = 32'(umin);
    thr_w[2] = 32'(pftrip_r);
    thr_w[3] = 32'(pfwarn_r);
    val_w[2] = 32'(pf_meas_i);
    val_w[3] = 32'(pf_meas_i);
    for (int i = 0; i < 4; i++) begin
      thr_w[i+4] = pwr_r[i];
    end
  end

  // one monitor per slot; voltage slots use their own gate
  for (genvar g = 0; g < VPM_NMON; g++) begin : g_mon
    vpm_mon_if mi ();
    assign mi.thr    = thr_w[g];
    assign mi.val    = val_w[g];
    assign mi.upper  = VPM_UPPER_KIND[g];
    assign mi.active = VPM_VOLT_KIND[g] ? vact_on : pact_on;
    assign mi.hyst   = hyst_r;
    assign mi.dly    = dly_r[g];
    assign mi.tick   = tick_r;
    assign cond_w[g]  = mi.cond;
    assign fired_w[g] = mi.fired;
    vpm_limit_mon u_mon (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .m     (mi.mon)
    );
  end

  // 0.1 s step prescaler shared by all delay timers
  always_comb begin
    if (pre_r >= DLY_STEP_CYC - 1) begin
      pre_nxt  = 32'h0000_0000;
      tick_nxt = 1'b1;
    end else begin
      pre_nxt  = pre_r + 32'h0000_0001;
      tick_nxt = 1'b0;
    end
  end

  // responses fold over the slots whose delay has run out
  always_comb begin
    sig_nxt = 1'b0;
    wrn_nxt = 1'b0;
    trp_nxt = 1'b0;
    for (int i = 0; i < VPM_NMON; i++) begin
      if (fired_w[i]) begin
        sig_nxt = sig_nxt | (resp_r[i] == VPM_RSP_SIGNAL);
        wrn_nxt = wrn_nxt | (resp_r[i] == VPM_RSP_WARN);
        trp_nxt = trp_nxt | (resp_r[i] == VPM_RSP_TRIP);
      end
    end
  end

  // register read image; unmapped words read zero
  assign adr_w = {wb_adr_i[7:2], 2'h0};
  always_comb begin
    rd_word = 32'h0000_0000;
    if (adr_w == VPM_CTRL_OFS) begin
      rd_word[3:0] = hyst_r;
      rd_word[VPM_CTRL_VACT_POS +: 2] = vact_r;
    end else if (adr_w == VPM_VLVL_OFS) begin
      rd_word[7:0] = vtrip_r;
      rd_word[VPM_LVL_WARN_POS +: 8] = vwarn_r;
    end else if (adr_w == VPM_PFLVL_OFS) begin
      rd_word[6:0] = pftrip_r;
      rd_word[VPM_LVL_WARN_POS +: 7] = pfwarn_r;
    end else if (adr_w[7:4] == VPM_PWR_OFS[7:4]) begin
      rd_word = pwr_r[adr_w[3:2]];
    end else if (adr_w[7:5] == VPM_RESP_OFS[7:5]) begin
      rd_word[1:0] = resp_r[adr_w[4:2]];
      rd_word[VPM_RESP_DLY_POS +: 8] = dly_r[adr_w[4:2]];
    end else if (adr_w == VPM_STAT_OFS) begin
      rd_word = {13'h0000, trp_r, wrn_r, sig_r, fired_w, cond_w};
    end
  end

  // classic wishbone: ack one cycle after the strobe, write at ack edge
  assign acc     = wb_cyc_i && wb_stb_i;
  assign wr_en   = acc && ack_r && wb_we_i;
  assign wr_word = vpm_merge(rd_word, wb_dat_i, wb_sel_i);
  always_comb begin
    ack_nxt = acc && !ack_r;
    dat_nxt = (acc && !ack_r) ? rd_word : dat_r;
  end

  // configuration write path; power factor levels above 100 are clamped to 100
  always_comb begin
    hyst_nxt   = hyst_r;
    vact_nxt   = vact_r;
    vtrip_nxt  = vtrip_r;
    vwarn_nxt  = vwarn_r;
    pftrip_nxt = pftrip_r;
    pfwarn_nxt = pfwarn_r;
    pwr_nxt    = pwr_r;
    resp_nxt   = resp_r;
    dly_nxt    = dly_r;
    if (wr_en) begin
      if (adr_w == VPM_CTRL_OFS) begin
        hyst_nxt = wr_word[3:0];
        vact_nxt = vpm_act_t'(wr_word[VPM_CTRL_VACT_POS +: 2]);
      end else if (adr_w == VPM_VLVL_OFS) begin
        vtrip_nxt = wr_word[7:0];
        vwarn_nxt = wr_word[VPM_LVL_WARN_POS +: 8];
      end else if (adr_w == VPM_PFLVL_OFS) begin
        pftrip_nxt = (wr_word[6:0] > VPM_PF_MAX) ? VPM_PF_MAX : wr_word[6:0];
        pfwarn_nxt = (wr_word[14:8] > VPM_PF_MAX) ? VPM_PF_MAX : wr_word[14:8];
      end else if (adr_w[7:4] == VPM_PWR_OFS[7:4]) begin
        pwr_nxt[adr_w[3:2]] = wr_word;
      end else if (adr_w[7:5] == VPM_RESP_OFS[7:5]) begin
        resp_nxt[adr_w[4:2]] = vpm_legal(wr_word[1:0],
                                         VPM_TRIP_KIND[adr_w[4:2]]);
        dly_nxt[adr_w[4:2]]  = wr_word[VPM_RESP_DLY_POS +: 8];
      end
    end
  end

  // all top-level state registered here; slot state sits in vpm_limit_mon
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hyst_r   <= VPM_HYST_RST;
      vact_r   <= VPM_ACT_ON_TPF;
      vtrip_r  <= VPM_VLVL_RST;
      vwarn_r  <= VPM_VLVL_RST;
      pftrip_r <= VPM_PF_RST;
      pfwarn_r <= VPM_PF_RST;
      for (int i = 0; i < 4; i++) begin
        pwr_r[i] <= VPM_PWR_RST;
      end
      for (int i = 0; i < VPM_NMON; i++) begin
        resp_r[i] <= VPM_RSP_OFF;
        dly_r[i]  <= VPM_DLY_RST;
      end
      ack_r  <= 1'b0;
      dat_r  <= 32'h0000_0000;
      sig_r  <= 1'b0;
      wrn_r  <= 1'b0;
      trp_r  <= 1'b0;
      pre_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      hyst_r   <= hyst_nxt;
      vact_r   <= vact_nxt;
      vtrip_r  <= vtrip_nxt;
      vwarn_r  <= vwarn_nxt;
      pftrip_r <= pftrip_nxt;
      pfwarn_r <= pfwarn_nxt;
      pwr_r    <= pwr_nxt;
      resp_r   <= resp_nxt;
      dly_r    <= dly_nxt;
      ack_r    <= ack_nxt;
      dat_r    <= dat_nxt;
      sig_r    <= sig_nxt;
      wrn_r    <= wrn_nxt;
      trp_r    <= trp_nxt;
      pre_r    <= pre_nxt;
      tick_r   <= tick_nxt;
    end
  end

  // outputs straight from flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign signal_o = sig_r;
  assign warn_o   = wrn_r;
  assign trip_o   = trp_r;
endmodule : vpm_monitor_top

// ==== tb/vpm_monitor_props.sv ====
// port checker for the limit monitor top
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module vpm_monitor_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // measured values and motor state
  input wire logic [11:0] u_l1_i,
  input wire logic [11:0] u_l2_i,
  input wire logic [11:0] u_l3_i,
  input wire logic        single_phase_i,
  input wire logic [6:0]  pf_meas_i,
  input wire logic [31:0] pwr_meas_i,
  input wire logic        motor_on_i,
  input wire logic        motor_started_i,
  input wire logic        test_position_feedback_i,
  // responses
  input wire logic        signal_o,
  input wire logic        warn_o,
  input wire logic        trip_o
);
  // quiet count: an output may only fall a few cycles after some cause
  logic [78:0] in_r;
  logic [2:0]  quiet_r;
  wire  [78:0] in_now = {u_l1_i, u_l2_i, u_l3_i, single_phase_i, pf_meas_i, pwr_meas_i,
                         motor_on_i, motor_started_i, test_position_feedback_i};
  always_ff @(posedge clk_i) begin
    in_r <= in_now;
    if (rst_i || in_now != in_r || (wb_cyc_i && wb_stb_i && wb_we_i))
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_out_low;
    !(signal_o || warn_o || trip_o) [*3];
  endsequence

  a_ack_after_req: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_holds: assert property (!wb_ack_o && !$past(rst_i) |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_reset_bus: assert property ($fell(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0)
    else $error("bus not quiet after reset");
  a_start_quiet: assert property ($fell(rst_i) |-> s_out_low)
    else $error("response right after reset");
  a_out_fall_cause: assert property ((quiet_r >= 3'h4) |->
    !$fell(signal_o) && !$fell(warn_o) && !$fell(trip_o))
    else $error("response dropped without cause");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
    (wb_adr_i[7:2] == 6'h03 || wb_adr_i[7:2] > 6'h10) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : vpm_monitor_props

bind vpm_monitor_top vpm_monitor_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .u_l1_i(u_l1_i), .u_l2_i(u_l2_i), .u_l3_i(u_l3_i), .single_phase_i(single_phase_i),
  .pf_meas_i(pf_meas_i), .pwr_meas_i(pwr_meas_i), .motor_on_i(motor_on_i),
  .motor_started_i(motor_started_i), .test_position_feedback_i(test_position_feedback_i),
  .signal_o(signal_o), .warn_o(warn_o), .trip_o(trip_o));

// ==== tb/vpm_meas_model.sv ====
// measuring module model: voltages, power factor and active power
// assumes targets change just after an edge; outputs follow one edge later
`timescale 1ns/1ps
module vpm_meas_model (
  // clock and targets
  input  wire logic             clk_i,
  input  wire logic [2:0][11:0] u_set_i,
  input  wire logic             one_ph_i,
  input  wire logic [6:0]       pf_set_i,
  input  wire logic [31:0]      pwr_set_i,
  // measured values
  output logic      [11:0]      u_l1_o,
  output logic      [11:0]      u_l2_o,
  output logic      [11:0]      u_l3_o,
  output logic                  single_phase_o,
  output logic      [6:0]       pf_meas_o,
  output logic      [31:0]      pwr_meas_o
);
  // a fresh sample every clock, like a converter updating each cycle
  always_ff @(posedge clk_i) begin
    u_l1_o         <= u_set_i[0];
    u_l2_o         <= u_set_i[1];
    u_l3_o         <= u_set_i[2];
    single_phase_o <= one_ph_i;
    pf_meas_o      <= pf_set_i;
    pwr_meas_o     <= pwr_set_i;
  end
endmodule : vpm_meas_model

// ==== tb/voltage_pf_power_limit_monitor_test.sv ====
// self-checking bench for the limit monitor top
// assumes the measuring model and the port checker compile alongside
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module voltage_pf_power_limit_monitor_test;
  import vpm_pkg::*;
  // clock, reset, bus
  logic             clk_i      = 1'b0;
  logic             rst_i      = 1'b1;
  logic             cyc        = 1'b0;
  logic             stb        = 1'b0;
  logic             we         = 1'b0;
  logic [7:0]       adr        = 8'h00;
  logic [31:0]      dat        = 32'h0;
  logic [3:0]       sel        = 4'hF;
  logic             wb_ack_o;
  logic [31:0]      wb_dat_o;
  // measuring model targets and motor state
  logic [2:0][11:0] u_set      = {3{12'h1F4}};
  logic             one_ph     = 1'b0;
  logic [6:0]       pf_set     = 7'h5A;
  logic [31:0]      pwr_set    = 32'h0;
  logic             mon        = 1'b0;
  logic             mst        = 1'b0;
  logic             test_position_feedback        = 1'b0;
  logic [11:0]      u1, u2, u3;
  logic             sp;
  logic [6:0]       pf;
  logic [31:0]      pwr;
  logic             sig, wrn, trp;
  logic [31:0]      q_dmy;
  int               num_errors = 0;
  int               n_checks   = 0;
  int               cyc_cnt    = 0;

  vpm_meas_model meas (.clk_i(clk_i), .u_set_i(u_set), .one_ph_i(one_ph), .pf_set_i(pf_set),
    .pwr_set_i(pwr_set), .u_l1_o(u1), .u_l2_o(u2), .u_l3_o(u3), .single_phase_o(sp),
    .pf_meas_o(pf), .pwr_meas_o(pwr));
  vpm_monitor_top #(.DLY_STEP_CYC(10)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .u_l1_i(u1), .u_l2_i(u2), .u_l3_i(u3),
    .single_phase_i(sp), .pf_meas_i(pf), .pwr_meas_i(pwr), .motor_on_i(mon),
    .motor_started_i(mst), .test_position_feedback_i(test_position_feedback), .signal_o(sig), .warn_o(wrn),
    .trip_o(trp));

  // 50 ns clock and a hang guard well above the expected run
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  // one classic cycle: request after an edge, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    // no cycle count assumed here; only the bench timeout ends the wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, 4'hF, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, 4'hF, q);
    `CHK(q, e)
  endtask : rd_chk
  // outputs are looked at mid-cycle, clear of the updating edge
  task automatic out_chk(input int n, input logic [2:0] e);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    `CHK({sig, wrn, trp}, e)
  endtask : out_chk
  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // defaults, unmapped place, clamping and refused response kinds
    rd_chk(VPM_CTRL_OFS, {22'h0, VPM_ACT_ON_TPF, 4'h0, VPM_HYST_RST});
    rd_chk(VPM_VLVL_OFS, 32'h0);
    rd_chk(VPM_PFLVL_OFS, 32'h0);
    rd_chk(8'h0C, 32'h0);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd_chk(8'h0C, 32'h0);
    rd_chk(8'h44, 32'h0);
    for (int i = 0; i < 4; i++) rd_chk(VPM_PWR_OFS + 8'(4 * i), VPM_PWR_RST);
    for (int i = 0; i < 8; i++) rd_chk(VPM_RESP_OFS + 8'(4 * i), {16'h0, VPM_DLY_RST, 8'h00});
    for (int i = 0; i < 8; i++) begin
      wr(VPM_RESP_OFS + 8'(4 * i), {16'h0, 8'(i), 6'h0, i[0] ? VPM_RSP_TRIP : VPM_RSP_WARN});
      rd_chk(VPM_RESP_OFS + 8'(4 * i), {16'h0, 8'(i), 8'h00});
    end
    wr(VPM_PWR_OFS, 32'hFFFF_FFFF);
    rd_chk(VPM_PWR_OFS, 32'hFFFF_FFFF);
    wr(VPM_VLVL_OFS, 32'h0000_FFFF);
    rd_chk(VPM_VLVL_OFS, 32'h0000_FFFF);
    xfer(1'b1, VPM_VLVL_OFS, 32'h0000_AA00, 4'h2, q_dmy);
    rd_chk(VPM_VLVL_OFS, 32'h0000_AAFF);
    wr(VPM_PFLVL_OFS, 32'h0000_7F7F);
    rd_chk(VPM_PFLVL_OFS, {17'h0, VPM_PF_MAX, 1'b0, VPM_PF_MAX});
    // undervoltage, motor off: trip 400 V, warn 480 V, hysteresis 10 percent
    wr(VPM_CTRL_OFS, {22'h0, VPM_ACT_ON, 4'h0, 4'hA});
    wr(VPM_VLVL_OFS, 32'h0000_3C32);
    wr(VPM_RESP_OFS, {24'h0, 6'h0, VPM_RSP_TRIP});
    rd_chk(VPM_RESP_OFS, {24'h0, 6'h0, VPM_RSP_TRIP});
    wr(VPM_RESP_OFS + 8'h04, {24'h0, 6'h0, VPM_RSP_SIGNAL});
    u_set <= {12'h1D6, 12'h1F4, 12'h1F4};
    out_chk(6, 3'b100);
    u_set <= {12'h186, 12'h1F4, 12'h1F4};
    out_chk(6, 3'b101);
    one_ph <= 1'b1;
    out_chk(6, 3'b100);
    one_ph <= 1'b0;
    out_chk(6, 3'b101);
    u_set <= {12'h1AE, 12'h1F4, 12'h1F4};
    out_chk(6, 3'b101);
    u_set <= {12'h1B9, 12'h1F4, 12'h1F4};
    out_chk(6, 3'b100);
    u_set <= {3{12'h211}};
    out_chk(6, 3'b000);
    // activity settings
    u_set <= {12'h186, 12'h211, 12'h211};
    wr(VPM_CTRL_OFS, {22'h0, VPM_ACT_ON_TPF, 4'h0, 4'hA});
    test_position_feedback <= 1'b1;
    out_chk(6, 3'b000);
    test_position_feedback <= 1'b0;
    out_chk(6, 3'b101);
    wr(VPM_CTRL_OFS, {22'h0, VPM_ACT_RUN, 4'h0, 4'hA});
    out_chk(6, 3'b000);
    mon <= 1'b1;
    out_chk(6, 3'b101);
    test_position_feedback <= 1'b1;
    out_chk(6, 3'b000);
    test_position_feedback <= 1'b0;
    // delay of three steps, restarted by a short clearing
    wr(VPM_RESP_OFS + 8'h04, 32'h0);
    u_set <= {3{12'h211}};
    wr(VPM_RESP_OFS, {16'h0, 8'h03, 6'h0, VPM_RSP_TRIP});
    u_set <= {12'h186, 12'h211, 12'h211};
    out_chk(12, 3'b000);
    u_set <= {3{12'h211}};
    out_chk(4, 3'b000);
    u_set <= {12'h186, 12'h211, 12'h211};
    out_chk(14, 3'b000);
    out_chk(30, 3'b001);
    wr(VPM_RESP_OFS, 32'h0);
    out_chk(4, 3'b000);
    // power factor: trip 50 percent, judged only when started
    wr(VPM_PFLVL_OFS, 32'h0000_0032);
    wr(VPM_RESP_OFS + 8'h08, {24'h0, 6'h0, VPM_RSP_TRIP});
    pf_set <= 7'h28;
    out_chk(6, 3'b000);
    mst <= 1'b1;
    out_chk(6, 3'b001);
    pf_set <= 7'h36;
    out_chk(6, 3'b001);
    rd_chk(VPM_STAT_OFS, 32'h0004_0707);
    pf_set <= 7'h38;
    out_chk(6, 3'b000);
    // active power: upper trip 1000 W, lower warn 500 W
    wr(VPM_PWR_OFS, 32'h0000_03E8);
    wr(VPM_PWR_OFS + 8'h0C, 32'h0000_01F4);
    wr(VPM_RESP_OFS + 8'h10, {24'h0, 6'h0, VPM_RSP_TRIP});
    wr(VPM_RESP_OFS + 8'h1C, {24'h0, 6'h0, VPM_RSP_WARN});
    pwr_set <= 32'h0000_03E9;
    out_chk(6, 3'b001);
    test_position_feedback <= 1'b1;
    out_chk(6, 3'b000);
    test_position_feedback <= 1'b0;
    pwr_set <= 32'h0000_0190;
    out_chk(6, 3'b010);
    mon <= 1'b0;
    out_chk(6, 3'b000);
    finish_test();
  end
endmodule : voltage_pf_power_limit_monitor_test
